// file: uar_map.svh
`ifndef UAR_MAP_SVH
`define UAR_MAP_SVH
`define UAR_ADR_CTRL 4'h0
`define UAR_ADR_STAT 4'h1
`define UAR_ADR_DATA 4'h2
`define UAR_ADR_IRQ_STAT 4'h3
`define UAR_ADR_IRQ_MASK 4'h4
`define UAR_ADR_DIV 4'h5
`define UAR_CTRL_EN 0
`define UAR_CTRL_DBL 1
`define UAR_STAT_RXC 0
`define UAR_STAT_FE 1
`define UAR_STAT_OVR 2
`define UAR_IRQ_RX 0
`define UAR_IRQ_FE 1
`define UAR_IRQ_OVR 2
`define UAR_DIV_RST 16'h0000
`define UAR_CTRL_RST 8'h00
`define UAR_NORM_SPB 5'h10
`define UAR_DBL_SPB 5'h08
`define UAR_NORM_FIRST 5'h08
`define UAR_DBL_FIRST 5'h04
`define UAR_LEN_MIN 4'h5
`define UAR_LEN_MAX 4'hA
`define UAR_LEN_RST 4'h8
`endif

// file: uar_pkg.sv
package uar_pkg;
	typedef enum logic [3:0] {
		UAR_IDLE = 4'h1,
		UAR_START = 4'h2,
		UAR_BITS = 4'h4,
		UAR_STOP = 4'h8
	} uar_state_t;
endpackage

// file: uar_sync.sv
`timescale 1ns/10ps
module uar_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// line
	input wire logic d_i,
	output logic q_o
);
	typedef struct packed {
		logic s1;
		logic s2;
	} uar_sync_st_t;
	uar_sync_st_t st_q;
	uar_sync_st_t st_d;
	always_comb
	begin
		st_d.s1 = d_i;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_q <= 2'h3;
		else
			st_q <= st_d;
	end
	assign q_o = st_q.s2;
endmodule

// file: uar_fifo.sv
`timescale 1ns/10ps
module uar_fifo #(
	parameter int W = 11,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	// fill side
	input wire logic wr_valid_i,
	input wire logic [W-1:0] wr_data_i,
	output logic wr_ready_o,
	// drain side
	input wire logic rd_ready_i,
	output logic rd_valid_o,
	output logic [W-1:0] rd_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} uar_fifo_st_t;
	uar_fifo_st_t st_q;
	uar_fifo_st_t st_d;
	logic push;
	logic pop;
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction
	assign wr_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
	assign rd_valid_o = (st_q.cnt != '0);
	assign rd_data_o = st_q.mem[st_q.rp];
	assign push = wr_valid_i && wr_ready_o;
	assign pop = rd_ready_i && rd_valid_o;
	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.mem[st_q.wp] = wr_data_i;
			st_d.wp = nxt(st_q.wp);
		end
		if (pop)
			st_d.rp = nxt(st_q.rp);
		if (push && !pop)
			st_d.cnt = st_q.cnt + 1'b1;
		else if (pop && !push)
			st_d.cnt = st_q.cnt - 1'b1;
		if (flush_i)
		begin
			st_d.wp = '0;
			st_d.rp = '0;
			st_d.cnt = '0;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule

// file: uar_rx.sv
`timescale 1ns/10ps
`include "uar_map.svh"
module uar_rx
	import uar_pkg::*;
#(
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial line
	input wire logic rxd_i,
	// interrupt
	output logic irq_o
);
	typedef struct packed {
		uar_state_t fsm;
		logic [4:0] smp;
		logic [15:0] tick;
		logic [3:0] bitn;
		logic [1:0] votes;
		logic [9:0] shf;
		logic push;
		logic fe;
		logic [7:0] ctrl;
		logic [3:0] len;
		logic [15:0] div;
		logic [2:0] ist;
		logic [2:0] imask;
		logic ovr;
		logic ack;
		logic [31:0] rdat;
	} uar_st_t;
	uar_st_t st_q;
	uar_st_t st_d;
	logic line;
	logic en;
	logic dbl;
	logic tick_p;
	logic [4:0] spb;
	logic [4:0] first;
	logic wr_ready;
	logic rd_valid;
	logic rd_pop;
	logic [10:0] rd_data;
	logic access;
	logic [3:0] widx;
	logic [2:0] ev;
	logic [4:0] cur;
	function automatic logic maj3(input logic [1:0] highs, input logic s);
		maj3 = (highs + {1'b0, s}) >= 2'h2;
	endfunction
	// first two of the three voting samples
	function automatic logic in_vote(input logic [4:0] n, input logic [4:0] f);
		in_vote = (n >= f) && (n < f + 5'h02);
	endfunction
	// third voting sample, where the bit is decided
	function automatic logic vote_end(input logic [4:0] n, input logic [4:0] f);
		vote_end = (n == f + 5'h02);
	endfunction
	uar_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(rxd_i),
		.q_o(line)
	);
	uar_fifo #(
		.W(11),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(!en),
		.wr_valid_i(st_q.push),
		.wr_data_i({st_q.fe, st_q.shf}),
		.wr_ready_o(wr_ready),
		.rd_ready_i(rd_pop),
		.rd_valid_o(rd_valid),
		.rd_data_o(rd_data)
	);
	assign en = st_q.ctrl[`UAR_CTRL_EN];
	assign dbl = st_q.ctrl[`UAR_CTRL_DBL];
	assign spb = dbl ? `UAR_DBL_SPB : `UAR_NORM_SPB;
	assign first = dbl ? `UAR_DBL_FIRST : `UAR_NORM_FIRST;
	// at or above, so a divisor lowered mid-count cannot stall sampling
	assign tick_p = (st_q.tick >= st_q.div);
	// number of the sample on the line at this tick
	assign cur = st_q.smp + 5'h01;
	assign access = cyc_i && stb_i && !st_q.ack;
	assign widx = adr_i[5:2];
	assign rd_pop = access && !we_i && widx == `UAR_ADR_DATA;
	assign ev[`UAR_IRQ_RX] = st_q.push && wr_ready;
	assign ev[`UAR_IRQ_FE] = st_q.push && wr_ready && st_q.fe;
	assign ev[`UAR_IRQ_OVR] = st_q.push && !wr_ready;
	assign dat_o = st_q.rdat;
	assign ack_o = st_q.ack;
	assign irq_o = |(st_q.ist & st_q.imask);
	always_comb
	begin
		st_d = st_q;
		st_d.push = 1'b0;
		st_d.ack = access;
		st_d.tick = tick_p ? 16'h0000 : st_q.tick + 16'h0001;
		// sample engine
		if (!en)
		begin
			st_d.fsm = UAR_IDLE;
			st_d.smp = 5'h00;
		end
		else if (tick_p)
		begin
			case (st_q.fsm)
				UAR_IDLE:
				begin
					st_d.smp = 5'h00;
					if (!line)
					begin
						st_d.fsm = UAR_START;
						st_d.smp = 5'h01;
						st_d.votes = 2'h0;
					end
				end
				UAR_START:
				begin
					st_d.smp = st_q.smp + 5'h01;
					if (in_vote(cur, first))
						st_d.votes = st_q.votes + {1'b0, line};
					if (vote_end(cur, first))
					begin
						if (maj3(st_q.votes, line))
							st_d.fsm = UAR_IDLE;
					end
					if (st_q.smp == spb)
					begin
						st_d.fsm = UAR_BITS;
						st_d.shf = 10'h000;
						st_d.smp = 5'h01;
						st_d.bitn = 4'h0;
						st_d.votes = 2'h0;
					end
				end
				UAR_BITS:
				begin
					st_d.smp = st_q.smp + 5'h01;
					if (in_vote(cur, first))
						st_d.votes = st_q.votes + {1'b0, line};
					if (vote_end(cur, first))
						st_d.shf[st_q.bitn] = maj3(st_q.votes, line);
					if (st_q.smp == spb)
					begin
						st_d.smp = 5'h01;
						st_d.votes = 2'h0;
						st_d.bitn = st_q.bitn + 4'h1;
						if (st_q.bitn + 4'h1 == st_q.len)
							st_d.fsm = UAR_STOP;
					end
				end
				UAR_STOP:
				begin
					st_d.smp = st_q.smp + 5'h01;
					if (in_vote(cur, first))
						st_d.votes = st_q.votes + {1'b0, line};
					if (vote_end(cur, first))
					begin
						st_d.fe = !maj3(st_q.votes, line);
						st_d.push = 1'b1;
						st_d.fsm = UAR_IDLE;
						st_d.smp = 5'h00;
						// double speed waits one more sample before a new start
						if (dbl)
							st_d.smp = 5'h1F;
					end
				end
				default:
				begin
					st_d.fsm = UAR_IDLE;
				end
			endcase
			if (st_q.fsm == UAR_IDLE && st_q.smp == 5'h1F)
			begin
				st_d.fsm = UAR_IDLE;
				st_d.smp = 5'h00;
			end
		end
		// overrun level: set on loss, cleared by a good store
		if (ev[`UAR_IRQ_OVR])
			st_d.ovr = 1'b1;
		else if (ev[`UAR_IRQ_RX])
			st_d.ovr = 1'b0;
		// register access
		st_d.rdat = 32'h0000_0000;
		if (access && we_i)
		begin
			case (widx)
				`UAR_ADR_CTRL:
				begin
					if (sel_i[0])
						st_d.ctrl = dat_i[7:0];
					if (sel_i[1] && dat_i[11:8] >= `UAR_LEN_MIN && dat_i[11:8] <= `UAR_LEN_MAX)
						st_d.len = dat_i[11:8];
				end
				`UAR_ADR_IRQ_STAT:
				begin
					if (sel_i[0])
						st_d.ist = st_q.ist & ~dat_i[2:0];
				end
				`UAR_ADR_IRQ_MASK:
				begin
					if (sel_i[0])
						st_d.imask = dat_i[2:0];
				end
				`UAR_ADR_DIV:
				begin
					if (sel_i[0])
						st_d.div[7:0] = dat_i[7:0];
					if (sel_i[1])
						st_d.div[15:8] = dat_i[15:8];
				end
				default:
				begin
					st_d.ctrl = st_d.ctrl;
				end
			endcase
		end
		else if (access)
		begin
			case (widx)
				`UAR_ADR_CTRL: st_d.rdat = {20'h00000, st_q.len, st_q.ctrl};
				`UAR_ADR_STAT: st_d.rdat = {29'h0, st_q.ovr, rd_valid && rd_data[10], rd_valid};
				`UAR_ADR_DATA: st_d.rdat = {21'h0, rd_valid && rd_data[10], rd_valid ? rd_data[9:0] : 10'h000};
				`UAR_ADR_IRQ_STAT: st_d.rdat = {29'h0, st_q.ist};
				`UAR_ADR_IRQ_MASK: st_d.rdat = {29'h0, st_q.imask};
				`UAR_ADR_DIV: st_d.rdat = {16'h0000, st_q.div};
				default: st_d.rdat = 32'h0000_0000;
			endcase
		end
		// events win over a clear in the same cycle
		st_d.ist = st_d.ist | ev;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q <= '0;
			st_q.fsm <= UAR_IDLE;
			st_q.ctrl <= `UAR_CTRL_RST;
			st_q.len <= `UAR_LEN_RST;
			st_q.div <= `UAR_DIV_RST;
		end
		else
			st_q <= st_d;
	end
endmodule

// file: uar_rx_assertions.sv
`timescale 1ns/10ps
module uar_rx_assertions (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus and interrupt
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq_o
);
	logic req;
	assign req = cyc_i && stb_i && !ack_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_follows: assert property (req |=> ack_o) else $error("ack late");
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
	a_ack_cause: assert property (ack_o |-> $past(req)) else $error("ack unasked");
	a_reset_quiet: assert property ($past(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0)
		else $error("busy after reset");
	a_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i[5:2] > 4'h5) |-> dat_o == 32'h0)
		else $error("unmapped read");
	a_stat_upper: assert property (
		ack_o && $past(!we_i && adr_i[5:2] == 4'h1) |-> dat_o[31:3] == 29'h0)
		else $error("status upper bits");
	a_data_upper: assert property (
		ack_o && $past(!we_i && adr_i[5:2] == 4'h2) |-> dat_o[31:11] == 21'h0)
		else $error("data upper bits");
	a_mask_off: assert property (
		req && we_i && sel_i[0] && adr_i[5:2] == 4'h4 && dat_i[2:0] == 3'h0 |=> !irq_o)
		else $error("irq despite mask");
	cover property (ack_o && !we_i);
	cover property (ack_o && we_i);
	cover property ($rose(irq_o));
endmodule
bind uar_rx uar_rx_assertions u_uar_rx_assertions (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .irq_o(irq_o));

// file: uar_tx_model.sv
`timescale 1ns/10ps
module uar_tx_model (
	// clock
	input wire logic clk_i,
	// line
	output logic rxd_o
);
	initial rxd_o = 1'b1;
	// start, bits lsb first, stop, one idle bit, all at nominal rate
	task automatic send(input logic [9:0] d, input int n, input logic stop, input int per);
		for (int i = -1; i <= n + 1; i++)
		begin
			rxd_o <= (i < 0) ? 1'b0 : (i >= n) ? (i == n ? stop : 1'b1) : d[i];
			repeat (per) @(posedge clk_i);
		end
	endtask
	task automatic glitch(input int w);
		rxd_o <= 1'b0;
		repeat (w) @(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (w) @(posedge clk_i);
	endtask
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [5:0] adr_i = 6'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic rxd_i;
	logic irq_o;
	int error_cnt = 0;
	int checks_done = 0;
	always #4 clk_i = ~clk_i;
	uar_rx u_uar_rx (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.rxd_i(rxd_i), .irq_o(irq_o));
	uar_tx_model u_uar_tx_model (.clk_i(clk_i), .rxd_o(rxd_i));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {a, 2'b00};
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 50)
		begin
			error_cnt++;
			end_sim;
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic t_regs;
		rd(4'h0, 32'h0000_0800, "ctrl");
		rd(4'h7, 32'h0, "unmapped");
		wr(4'h0, 32'h0000_0400);
		rd(4'h0, 32'h0000_0800, "len4");
		wr(4'h5, 32'h0000_ABCD);
		rd(4'h5, 32'h0000_ABCD, "div");
		wr(4'h5, 32'h0000_0000);
		$display("regs done");
	endtask
	task automatic t_frames;
		wr(4'h4, 32'h7);
		wr(4'h0, 32'h0000_0801);
		u_uar_tx_model.glitch(8);
		u_uar_tx_model.send(10'h0A5, 8, 1'b1, 16);
		u_uar_tx_model.send(10'h03C, 8, 1'b0, 16);
		u_uar_tx_model.send(10'h05A, 8, 1'b1, 16);
		rd(4'h1, 32'h5, "stat");
		chk("irq", 32'h1, {31'h0, irq_o});
		rd(4'h3, 32'h7, "irq_stat");
		rd(4'h4, 32'h7, "mask");
		rd(4'h2, 32'h0A5, "frame1");
		rd(4'h1, 32'h7, "stat_fe");
		rd(4'h2, 32'h43C, "frame2");
		wr(4'h3, 32'h7);
		chk("irq_clr", 32'h0, {31'h0, irq_o});
		$display("frames done");
	endtask
	task automatic t_lengths;
		wr(4'h0, 32'h0000_0503);
		u_uar_tx_model.send(10'h016, 5, 1'b1, 8);
		rd(4'h2, 32'h016, "dbl5");
		wr(4'h0, 32'h0000_0A01);
		u_uar_tx_model.send(10'h2D3, 10, 1'b1, 16);
		rd(4'h2, 32'h2D3, "norm10");
		$display("lengths done");
	endtask
	task automatic t_disable;
		wr(4'h0, 32'h0000_0801);
		u_uar_tx_model.send(10'h0C3, 8, 1'b1, 16);
		// disable lands inside the start bit
		fork
			u_uar_tx_model.send(10'h0FF, 8, 1'b1, 16);
			wr(4'h0, 32'h0000_0800);
		join
		rd(4'h1, 32'h0, "flushed");
		wr(4'h0, 32'h0000_0801);
		u_uar_tx_model.send(10'h081, 8, 1'b1, 16);
		rd(4'h2, 32'h081, "after");
		$display("disable done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_frames;
		t_lengths;
		t_disable;
		end_sim;
	end
	initial
	begin
		#200000;
		error_cnt++;
		end_sim;
	end
endmodule
